//--- scc_params.svh
// Constants of the converter control block: offsets, field positions,
// reset values and timing counts. Included by the package, scc_conv_clk and scc_sar_ctrl.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH

// System clock period and conversion clock period, in nanoseconds.
`define SCC_SYS_PERIOD_NS    25
`define SCC_CONV_PERIOD_NS   100
// Conversion clock period in system clocks (least time, rounded up).
`define SCC_CONV_DIV \
  ((`SCC_CONV_PERIOD_NS + `SCC_SYS_PERIOD_NS - 1) / `SCC_SYS_PERIOD_NS)

// Register byte offsets.
`define SCC_OFS_CTRL         8'h00
`define SCC_OFS_RESULT       8'h04
`define SCC_OFS_STATUS       8'h08
`define SCC_OFS_IRQ_STAT     8'h0c
`define SCC_OFS_IRQ_MASK     8'h10

// Control register fields.
`define SCC_CTRL_HIGH_Z      0
`define SCC_CTRL_TURBO       1
`define SCC_CTRL_SPAN        2
`define SCC_CTRL_RESET       3'h0

// Status register fields.
`define SCC_STAT_BUSY        0
`define SCC_STAT_CHAIN       1
`define SCC_STAT_BUSY_DRV    2

// Interrupt bits.
`define SCC_IRQ_DONE         0
`define SCC_IRQ_IGNORED      1
`define SCC_IRQ_RESET        2'h0

// Result codes.
`define SCC_CODE_POS_FS      16'h7fff
`define SCC_CODE_NEG_FS      16'h8000
`define SCC_CODE_RESET       16'h0000
`define SCC_TRIAL_MSB        16'h8000

`endif

//--- scc_pkg.sv
// Types shared by the converter control block.
// Assumes scc_params.svh is reachable on the include path.
`include "scc_params.svh"

package scc_pkg;

  // One-hot sequencer states.
  typedef enum logic [5:0] {
    SCC_IDLE    = 6'h01,
    SCC_OPEN_SW = 6'h02,
    SCC_GND     = 6'h04,
    SCC_TRIAL   = 6'h08,
    SCC_DECIDE  = 6'h10,
    SCC_LATCH   = 6'h20
  } scc_state_e;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scc_bus_req_s;

  // Switch and array controls towards the analog core.
  typedef struct packed {
    logic        pos_comparator_ground_switch;
    logic        neg_comparator_ground_switch;
    logic        array_to_input;
    logic        array_to_gnd;
    logic [15:0] dac_trial;
    logic        power_en;
  } scc_analog_s;

  // Complete state of the control block.
  typedef struct packed {
    logic [1:0]  cnv_sync;
    logic [1:0]  sdi_sync;
    logic [1:0]  cmp_sync;
    logic [1:0]  ovr_sync;
    logic [1:0]  und_sync;
    logic        cnv_prev;
    scc_state_e  st;
    logic [3:0]  bit_idx;
    logic [15:0] trial;
    logic [15:0] result;
    logic        chain_mode;
    logic        busy_drv;
    logic        done;
    logic [2:0]  ctrl;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [31:0] rdata;
  } scc_regs_s;

endpackage

//--- scc_conv_clk.sv
// Internal conversion clock: a tick every DIV system clocks while run is
// high. Assumes one system clock domain with asynchronous active-low reset.
`timescale 1ns/100ps
`include "scc_params.svh"

module scc_conv_clk
  import scc_pkg::*;
#(
  parameter int DIV = `SCC_CONV_DIV
)
(
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  output logic      tick_o
);

  // Synchroniser delay on the comparator needs at least this many cycles,
  // and the counter below is eight bits wide.
  if (DIV < 4 || DIV > 255)
  begin : g_bad_div
    $error("scc_conv_clk: DIV out of range");
  end

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // Counter is held at zero while stopped so it burns nothing between runs.
  always_comb
  begin
    cnt_nxt = 8'h00;
    if (run_i && cnt_r != 8'(DIV - 1))
      cnt_nxt = cnt_r + 8'h01;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_nxt;
  end

  assign tick_o = run_i && (cnt_r == 8'(DIV - 1));

endmodule

//--- scc_sar_ctrl.sv
// Successive-approximation control of a 16-bit differential converter,
// with a small register port and a level interrupt.
// Assumes pins and analog comparator outputs are asynchronous to sys_clk_i,
// that the analog core settles a trial within one conversion tick, that
// the range detectors already follow the span compression setting, and
// that the host holds convert_start high for at least three clocks.
`timescale 1ns/100ps
`include "scc_params.svh"

module scc_sar_ctrl
  import scc_pkg::*;
#(
  parameter int CONV_DIV = `SCC_CONV_DIV
)
(
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // Pins from the host.
  input  wire logic        convert_start_i,
  input  wire logic        serial_in_config_i,
  // Analog comparator and range detectors.
  input  wire logic        comparator_i,
  input  wire logic        over_range_i,
  input  wire logic        under_range_i,
  // Register port.
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Analog core controls.
  output logic             pos_comparator_ground_switch_o,
  output logic             neg_comparator_ground_switch_o,
  output logic             array_to_input_o,
  output logic             array_to_gnd_o,
  output logic      [15:0] dac_trial_o,
  output logic             power_en_o,
  output logic             high_z_o,
  output logic             span_comp_o,
  output logic             turbo_o,
  // Result side.
  output logic      [15:0] result_o,
  output logic             busy_o,
  output logic             eoc_o,
  output logic             busy_drive_en_o,
  output logic             chain_mode_o,
  output logic             irq_o
);

  // Registered state, its next value and the decoded helper signals.
  scc_regs_s   q_r;
  scc_regs_s   q_nxt;
  scc_bus_req_s req;
  scc_analog_s ana;
  logic        tick;
  logic        run;
  logic        start_edge;
  logic        cmp_s;
  logic [15:0] offset_code;

  // Fewer than four system clocks per tick would let a decision read a
  // comparator value still inside its synchroniser, and the divider in
  // the tick generator is eight bits wide.
  if (CONV_DIV < 4 || CONV_DIV > 255)
  begin : g_bad_div
    $error("scc_sar_ctrl: CONV_DIV out of range");
  end

  // Group the bus pins into one request.
  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.wr    = reg_wr_i;
  assign req.rd    = reg_rd_i;

  // Conversion clock runs only outside idle. A conversion takes 34 ticks
  // plus one latch cycle once the start edge has left the synchroniser.
  assign run = (q_r.st != SCC_IDLE);

  // The divider stops with the sequencer, so it toggles nothing while the block is idle; the synchronisers still follow their inputs.
  scc_conv_clk #(
    .DIV       (CONV_DIV)
  ) u_conv_clk (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .run_i     (run),
    .tick_o    (tick)
  );

  // A start edge is seen past the synchroniser only. cnv_prev resets low,
  // the idle level of the pin, so leaving reset gives no false edge.
  assign start_edge = q_r.cnv_sync[1] && !q_r.cnv_prev;
  assign cmp_s      = q_r.cmp_sync[1];

  // Offset-binary search result turned to two's complement by the MSB.
  // The search itself runs in offset binary, so no adder is needed here.
  assign offset_code = {~q_r.trial[15], q_r.trial[14:0]};

  // Next-state logic for the whole block.
  always_comb
  begin
    q_nxt = q_r;
    // Two-flop synchronisers for every pin and analog flag. The mode pin
    // and range detectors are read only at fixed points, so their lag of
    // two cycles costs nothing.
    q_nxt.cnv_sync = {q_r.cnv_sync[0], convert_start_i};
    q_nxt.sdi_sync = {q_r.sdi_sync[0], serial_in_config_i};
    q_nxt.cmp_sync = {q_r.cmp_sync[0], comparator_i};
    q_nxt.ovr_sync = {q_r.ovr_sync[0], over_range_i};
    q_nxt.und_sync = {q_r.und_sync[0], under_range_i};
    q_nxt.cnv_prev = q_r.cnv_sync[1];
    // End of conversion is a pulse of one cycle.
    q_nxt.done     = 1'b0;

    // Software clears interrupt bits first, so hardware sets below win.
    if (req.wr && req.addr == `SCC_OFS_IRQ_STAT)
      q_nxt.irq_stat = q_r.irq_stat & ~req.wdata[1:0];
    if (req.wr && req.addr == `SCC_OFS_IRQ_MASK)
      q_nxt.irq_mask = req.wdata[1:0];
    // Option bits act on the analog core at once; changing them during a
    // conversion is allowed but spoils that result.
    if (req.wr && req.addr == `SCC_OFS_CTRL)
      q_nxt.ctrl = req.wdata[2:0];

    // Sequencer: acquisition, switch opening, grounding, then one trial and
    // one decision per bit, and a single latch cycle.
    case (q_r.st)
      SCC_IDLE:
      begin
        // Acquisition: wait for a start edge and note the readout mode.
        if (start_edge)
        begin
          q_nxt.st         = SCC_OPEN_SW;
          q_nxt.chain_mode = !q_r.sdi_sync[1];
          // The busy drive is withdrawn once a new conversion starts.
          q_nxt.busy_drv   = 1'b0;
        end
      end
      SCC_OPEN_SW:
      begin
        // Ground switches open; the arrays still hold the input for a tick.
        if (tick)
          q_nxt.st = SCC_GND;
      end
      SCC_GND:
      begin
        // Arrays on ground; load the top trial bit for the first decision.
        if (tick)
        begin
          q_nxt.st      = SCC_TRIAL;
          q_nxt.bit_idx = 4'hf;
          q_nxt.trial   = `SCC_TRIAL_MSB;
        end
      end
      SCC_TRIAL:
      begin
        // One conversion tick of settling before the decision.
        if (tick)
          q_nxt.st = SCC_DECIDE;
      end
      SCC_DECIDE:
      begin
        if (tick)
        begin
          // Comparator low means the trial overshot: drop this bit.
          if (!cmp_s)
            q_nxt.trial[q_r.bit_idx] = 1'b0;
          if (q_r.bit_idx == 4'h0)
            q_nxt.st = SCC_LATCH;
          else
          begin
            // Set the next lower bit as the new trial; kept bits stay set.
            q_nxt.bit_idx = q_r.bit_idx - 4'h1;
            q_nxt.trial[q_r.bit_idx - 4'h1] = 1'b1;
            q_nxt.st = SCC_TRIAL;
          end
        end
      end
      SCC_LATCH:
      begin
        // Range detectors override so a wild input never wraps.
        if (q_r.ovr_sync[1])
          q_nxt.result = `SCC_CODE_POS_FS;
        else if (q_r.und_sync[1])
          q_nxt.result = `SCC_CODE_NEG_FS;
        else
          q_nxt.result = offset_code;
        q_nxt.done     = 1'b1;
        // The mode pins are seen past their synchronisers, so a pin that
        // moves in the last two cycles of a conversion may be seen late.
        q_nxt.busy_drv = !q_r.chain_mode &&
                         (!q_r.sdi_sync[1] || !q_r.cnv_sync[1]);
        // Raise the done flag; a clear written in this cycle loses.
        q_nxt.irq_stat[`SCC_IRQ_DONE] = 1'b1;
        q_nxt.st = SCC_IDLE;
      end
      default:
      begin
        // An illegal code falls back to acquisition instead of hanging.
        q_nxt.st = SCC_IDLE;
      end
    endcase

    // Edges while converting are dropped but reported. Dropping them keeps
    // each result tied to its own sample; the flag tells software that a
    // request was lost.
    if (q_r.st != SCC_IDLE && start_edge)
      q_nxt.irq_stat[`SCC_IRQ_IGNORED] = 1'b1;

    // Read data stands in the cycle after the strobe only.
    // Unmapped addresses read as zero, and reads have no side effects.
    q_nxt.rdata = 32'h0000_0000;
    if (req.rd)
    begin
      case (req.addr)
        `SCC_OFS_CTRL:     q_nxt.rdata = {29'h0, q_r.ctrl};
        `SCC_OFS_RESULT:   q_nxt.rdata = {16'h0000, q_r.result};
        `SCC_OFS_STATUS:   q_nxt.rdata = {29'h0, q_r.busy_drv,
                                          q_r.chain_mode, run};
        `SCC_OFS_IRQ_STAT: q_nxt.rdata = {30'h0, q_r.irq_stat};
        `SCC_OFS_IRQ_MASK: q_nxt.rdata = {30'h0, q_r.irq_mask};
        default:           q_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // The whole state registers here; reset gives constants only.
  // The state code loads the one-hot idle value during reset.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q_r            <= '0;
      q_r.st         <= SCC_IDLE;
      q_r.result     <= `SCC_CODE_RESET;
      q_r.ctrl       <= `SCC_CTRL_RESET;
      q_r.irq_stat   <= `SCC_IRQ_RESET;
      q_r.irq_mask   <= `SCC_IRQ_RESET;
    end
    else
      q_r <= q_nxt;
  end

  // Switch sequencing: ground switches close only while acquiring, the
  // arrays leave the inputs one conversion tick after they open.
  // Each control but dac_trial decodes the one-hot state, so it changes once a step.
  always_comb
  begin
    ana.pos_comparator_ground_switch = (q_r.st == SCC_IDLE);
    ana.neg_comparator_ground_switch = (q_r.st == SCC_IDLE);
    ana.array_to_input = (q_r.st == SCC_IDLE) ||
                         (q_r.st == SCC_OPEN_SW);
    ana.array_to_gnd   = !ana.array_to_input;
    ana.dac_trial      = q_r.trial;
    ana.power_en       = run;
  end

  // Drive the analog core from the decoded controls.
  assign pos_comparator_ground_switch_o = ana.pos_comparator_ground_switch;
  assign neg_comparator_ground_switch_o = ana.neg_comparator_ground_switch;
  assign array_to_input_o = ana.array_to_input;
  assign array_to_gnd_o   = ana.array_to_gnd;
  assign dac_trial_o      = ana.dac_trial;
  assign power_en_o       = ana.power_en;

  // Option bits; the analog scaling and range detectors follow span_comp.
  assign high_z_o    = q_r.ctrl[`SCC_CTRL_HIGH_Z];
  assign turbo_o     = q_r.ctrl[`SCC_CTRL_TURBO];
  assign span_comp_o = q_r.ctrl[`SCC_CTRL_SPAN];

  // Result side; all but busy_o come straight from flip-flops.
  assign result_o        = q_r.result;
  assign busy_o          = run;
  assign eoc_o           = q_r.done;
  assign busy_drive_en_o = q_r.busy_drv;
  assign chain_mode_o    = q_r.chain_mode;
  assign reg_rdata_o     = q_r.rdata;

  // Level interrupt: high while any unmasked sticky bit is set.
  assign irq_o           = |(q_r.irq_stat & q_r.irq_mask);

endmodule

//--- scc_analog_model.sv
// Analog core stand-in: holds the input and compares it with the trial code.
// Assumes offset-binary trial codes and one system clock.
`timescale 1ns/100ps

module scc_analog_model
(
  input  wire logic        sys_clk_i,
  input  wire logic [15:0] vin_i,
  input  wire logic        ovr_i,
  input  wire logic        und_i,
  input  wire logic        array_to_input_i,
  input  wire logic [15:0] dac_trial_i,
  output logic             comparator_o,
  output logic             over_range_o,
  output logic             under_range_o
);
  logic [15:0] held_r;
  logic        idle_r = 1'b0;

  // Arrays track the input while tied to it, and hold once they leave it.
  always @(posedge sys_clk_i)
  begin
    if (array_to_input_i)
      held_r <= vin_i;
    idle_r <= ~idle_r;
  end

  // An unbalanced comparator in acquisition means nothing, so it toggles.
  assign comparator_o  = array_to_input_i ? idle_r : held_r >= dac_trial_i;
  assign over_range_o  = ovr_i;
  assign under_range_o = und_i;
endmodule

//--- scc_sar_ctrl_monitor.sv
// Port checker of the converter control, bound to every scc_sar_ctrl.
// Assumes one clock domain with asynchronous active-low reset.
`timescale 1ns/100ps

module scc_sar_ctrl_monitor
#(
  parameter int CONV_DIV = 4
)
(
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        pos_comparator_ground_switch_o,
  input wire logic        neg_comparator_ground_switch_o,
  input wire logic        array_to_input_o,
  input wire logic        array_to_gnd_o,
  input wire logic [15:0] dac_trial_o,
  input wire logic        power_en_o,
  input wire logic [15:0] result_o,
  input wire logic        busy_o,
  input wire logic        eoc_o,
  input wire logic        busy_drive_en_o,
  input wire logic        chain_mode_o
);
  logic [11:0] busy_cnt_r;

  // Busy length count; the search has a fixed tick budget.
  always_ff @(posedge sys_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_cnt_r <= 12'h000;
    else
      busy_cnt_r <= busy_o ? busy_cnt_r + 12'h001 : 12'h000;
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_open_only;
    !pos_comparator_ground_switch_o && !neg_comparator_ground_switch_o
      && array_to_input_o && !array_to_gnd_o;
  endsequence
  property p_open_first;
    $fell(pos_comparator_ground_switch_o) |->
      s_open_only [*3] ##[1:3] (array_to_gnd_o && !array_to_input_o);
  endproperty
  a_open_first: assert property (p_open_first)
    else $error("arrays grounded before switches opened");
  property p_gnd_after_open;
    $rose(array_to_gnd_o) |-> $past(!neg_comparator_ground_switch_o);
  endproperty
  a_gnd_after_open: assert property (p_gnd_after_open)
    else $error("ground switch still closed");
  property p_msb_first;
    $rose(array_to_gnd_o) |-> ##[0:8] dac_trial_o == 16'h8000;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("first trial is not the top bit");
  property p_busy_len;
    $fell(busy_o) |-> busy_cnt_r >= 34 * CONV_DIV - 1
      && busy_cnt_r <= 34 * CONV_DIV + 3;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length wrong");
  property p_result_at_eoc;
    $changed(result_o) |-> eoc_o;
  endproperty
  a_result_at_eoc: assert property (p_result_at_eoc)
    else $error("result changed outside end of conversion");
  property p_eoc_pulse;
    eoc_o |=> !eoc_o ##[0:1] !busy_o;
  endproperty
  a_eoc_pulse: assert property (p_eoc_pulse)
    else $error("end of conversion not a single pulse");
  property p_power_idle;
    !power_en_o |-> pos_comparator_ground_switch_o && array_to_input_o;
  endproperty
  a_power_idle: assert property (p_power_idle)
    else $error("idle without acquisition set-up");
  property p_power_busy;
    $fell(busy_o) |-> !power_en_o && eoc_o;
  endproperty
  a_power_busy: assert property (p_power_busy)
    else $error("power not dropped at end of conversion");
  property p_chain_hold;
    busy_o && $past(busy_o, 2) |-> $stable(chain_mode_o);
  endproperty
  a_chain_hold: assert property (p_chain_hold)
    else $error("mode changed during conversion");
  property p_drive_cs;
    busy_drive_en_o |-> !chain_mode_o;
  endproperty
  a_drive_cs: assert property (p_drive_cs)
    else $error("busy drive in chain mode");
  property p_rdata_idle;
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");
endmodule

bind scc_sar_ctrl scc_sar_ctrl_monitor #(.CONV_DIV(CONV_DIV)) i_mon (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .array_to_input_o(array_to_input_o),
  .pos_comparator_ground_switch_o(pos_comparator_ground_switch_o),
  .neg_comparator_ground_switch_o(neg_comparator_ground_switch_o),
  .array_to_gnd_o(array_to_gnd_o), .dac_trial_o(dac_trial_o),
  .power_en_o(power_en_o), .result_o(result_o), .busy_o(busy_o),
  .eoc_o(eoc_o), .busy_drive_en_o(busy_drive_en_o),
  .chain_mode_o(chain_mode_o));

//--- test_scc_sar_ctrl.sv
// Testbench of the converter control with a stand-in analog core.
// Assumes the design's default tick divider of four system clocks.
`timescale 1ns/100ps

module test_scc_sar_ctrl;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, convert_start_i = 1'b0;
  logic serial_in_config_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic cmp, ovr_s, und_s, ovr = 1'b0, und = 1'b0;
  logic [15:0] vin = 16'h0000, trial, result_o;
  logic pos_sw, neg_sw, to_in, to_gnd, pwr, high_z, span, turbo;
  logic busy_o, eoc_o, busy_drive_en_o, chain_mode_o, irq_o;
  int mismatches = 0, check_count = 0;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic [15:0] tab [6] = '{16'h8000, 16'h8001, 16'h7fff, 16'h0001,
                           16'hffff, 16'h0000};
  logic [15:0] code [6] = '{16'h0000, 16'h0001, 16'hffff, 16'h8001,
                            16'h7fff, 16'h8000};

  scc_sar_ctrl #(.CONV_DIV(4)) i_scc_sar_ctrl (.sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i), .convert_start_i(convert_start_i),
    .serial_in_config_i(serial_in_config_i), .comparator_i(cmp),
    .over_range_i(ovr_s), .under_range_i(und_s), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .pos_comparator_ground_switch_o(pos_sw),
    .neg_comparator_ground_switch_o(neg_sw), .array_to_input_o(to_in),
    .array_to_gnd_o(to_gnd), .dac_trial_o(trial), .power_en_o(pwr),
    .high_z_o(high_z), .span_comp_o(span), .turbo_o(turbo),
    .result_o(result_o), .busy_o(busy_o), .eoc_o(eoc_o),
    .busy_drive_en_o(busy_drive_en_o), .chain_mode_o(chain_mode_o),
    .irq_o(irq_o));
  scc_analog_model i_scc_analog_model (.sys_clk_i(sys_clk_i), .vin_i(vin),
    .ovr_i(ovr), .und_i(und), .array_to_input_i(to_in),
    .dac_trial_i(trial), .comparator_o(cmp), .over_range_o(ovr_s),
    .under_range_o(und_s));

  // Clock at 40 MHz.
  initial
    forever #12.5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk("reg_rdata_o", reg_rdata_o, exp);
  endtask

  // Start pulse, then a bounded wait for the end-of-conversion pulse.
  task automatic convert(input logic [15:0] v, input logic o, u, s);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    vin <= v;
    ovr <= o;
    und <= u;
    serial_in_config_i <= s;
    convert_start_i    <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    convert_start_i <= 1'b0;
    do
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    while (eoc_o !== 1'b1 && n < 400);
    if (n == 400)
      mismatches++;
  endtask

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well beyond the eleven conversions of the run.
  initial
  begin
    #(25 * 20000);
    mismatches++;
    test_done();
  end

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    #1 chk("idle", 32'({pwr, busy_o, irq_o, pos_sw, to_in}), 32'h3);
    foreach (ofs[i])
      reg_check(ofs[i], 32'h0);
    for (int b = 0; b < 3; b++)
    begin
      reg_write(8'h00, 32'h1 << b);
      reg_check(8'h00, 32'h1 << b);
      chk("ctrl", 32'({span, turbo, high_z}), 32'h1 << b);
    end
    reg_write(8'h00, 32'h0);
    reg_write(8'h10, 32'h3);
    foreach (tab[i])
    begin
      convert(tab[i], 1'b0, 1'b0, 1'b1);
      chk("result", 32'(result_o), 32'(code[i]));
      chk("drive", 32'({busy_drive_en_o, chain_mode_o}), 32'h2);
      reg_check(8'h0c, 32'h1);
      chk("irq", 32'(irq_o), 32'h1);
      reg_write(8'h0c, 32'h1);
      reg_check(8'h04, 32'(code[i]));
      chk("irq", 32'(irq_o), 32'h0);
    end
    convert(16'h1234, 1'b1, 1'b0, 1'b1);
    chk("result", 32'(result_o), 32'h7fff);
    convert(16'h1234, 1'b0, 1'b1, 1'b1);
    chk("result", 32'(result_o), 32'h8000);
    reg_write(8'h00, 32'h4);
    convert(16'h4321, 1'b1, 1'b0, 1'b0);
    chk("result", 32'(result_o), 32'h7fff);
    reg_check(8'h08, 32'h2);
    reg_write(8'h10, 32'h0);
    convert(16'hedcb, 1'b0, 1'b1, 1'b1);
    chk("result", 32'(result_o), 32'h8000);
    chk("masked irq", 32'(irq_o), 32'h0);
    reg_write(8'h0c, 32'h3);
    reg_write(8'h10, 32'h3);
    // A second start edge in mid-conversion must be dropped.
    fork
      convert(16'h9abc, 1'b0, 1'b0, 1'b1);
      begin
        repeat (40) @(posedge sys_clk_i);
        convert_start_i <= 1'b1;
      end
    join
    chk("result", 32'(result_o), 32'h1abc);
    // Both mode pins still high at completion, so no busy drive.
    chk("drive", 32'({busy_drive_en_o, chain_mode_o}), 32'h0);
    @(posedge sys_clk_i);
    convert_start_i <= 1'b0;
    reg_check(8'h0c, 32'h3);
    repeat (10) @(posedge sys_clk_i);
    #1 chk("busy", 32'(busy_o), 32'h0);
    test_done();
  end
endmodule
